/* File: rtl/step_dir_input.sv */
// Input-side control logic of a two-phase stepper driver: step and direction
// decoding, windings-off, base-step select, excitation position and status.
// Assumes pins arrive asynchronous and a host reaches registers over Avalon-MM.

module step_dir_input
  import step_dir_pkg::*;
#(
  parameter int STANDSTILL_CYCLES = STANDSTILL_CYC
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  // Controller pins
  input  wire logic        stepPulseIn,
  input  wire logic        directionIn,
  input  wire logic        windingsOffIn,
  input  wire logic        baseStepSelIn,
  // Driver outputs
  output logic             windingEnable,
  output logic             stepStrobe,
  output logic             stepCw,
  output logic [10:0]      phasePos,
  output logic             currentReducedOut,
  output logic             faultOut,
  output logic             excitationHomeOut,
  output logic             irq,
  // Avalon-MM slave
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [3:0] meta_q, sync_q;
  logic       pulsePrev_q;

  // Two flops on every pin before any logic looks at it.
  always_ff @(posedge clock) begin
    if (srst) begin
      meta_q      <= 4'h0;
      sync_q      <= 4'h0;
      pulsePrev_q <= 1'b0;
    end else begin
      meta_q      <= {baseStepSelIn, windingsOffIn, directionIn, stepPulseIn};
      sync_q      <= meta_q;
      pulsePrev_q <= sync_q[0];
    end
  end

  logic pulseFall;
  logic dirSync;
  logic windOffSync;
  logic baseSelSync;
  assign pulseFall   = pulsePrev_q & ~sync_q[0];
  assign dirSync     = sync_q[1];
  assign windOffSync = sync_q[2];
  assign baseSelSync = sync_q[3];

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic [3:0] divSel_q;
  logic       faultOk_q;
  logic       accept;

  // Steps taken while tripped or de-energised are dropped: no current, no motion.
  assign accept = pulseFall & faultOk_q & ~windOffSync;

  // Divisions per base step, indexed by the resolution selector.
  // Non-power-of-two divisions are truncated onto the 128-unit grid.
  localparam logic [7:0] DIV_TABLE [16] = '{
    8'd1,  8'd2,  8'd4,  8'd5,  8'd8,  8'd9,  8'd10, 8'd16,
    8'd18, 8'd20, 8'd32, 8'd36, 8'd40, 8'd64, 8'd80, 8'd128};

  // Excitation works in finest units; one step advances by the active size.
  logic [10:0] stepSize;
  logic [10:0] homeCycle;
  assign homeCycle = 11'(BASE_PER_HOME * 128);
  always_comb begin
    if (baseSelSync) begin
      stepSize = 11'd128;
    end else begin
      stepSize = 11'(128 / int'(DIV_TABLE[divSel_q]));
    end
  end

  // ----------------------------------------
  // Excitation position
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      phasePos <= 11'h000;
    end else if (accept) begin
      if (dirSync) begin
        phasePos <= (phasePos + stepSize >= homeCycle) ?
                    phasePos + stepSize - homeCycle : phasePos + stepSize;
      end else begin
        phasePos <= (phasePos < stepSize) ?
                    phasePos + homeCycle - stepSize : phasePos - stepSize;
      end
    end
  end

  // Step strobe and its direction mirror each accepted fall.
  always_ff @(posedge clock) begin
    if (srst) begin
      stepStrobe <= 1'b0;
      stepCw     <= 1'b0;
    end else begin
      stepStrobe <= accept;
      stepCw     <= accept ? dirSync : stepCw;
    end
  end

  // Home flag follows the counter one cycle later.
  always_ff @(posedge clock) begin
    if (srst) begin
      excitationHomeOut <= 1'b1;
    end else begin
      excitationHomeOut <= (phasePos == 11'h000);
    end
  end

  // ----------------------------------------
  // Winding current, standstill, fault
  // ----------------------------------------
  logic [31:0] idle_q;

  always_ff @(posedge clock) begin
    if (srst) begin
      windingEnable <= 1'b0;
    end else begin
      windingEnable <= ~windOffSync & faultOk_q;
    end
  end

  // Standstill reduction after a long enough gap without steps.
  always_ff @(posedge clock) begin
    if (srst || accept) begin
      idle_q            <= 32'h0;
      currentReducedOut <= 1'b0;
    end else begin
      idle_q            <= (idle_q < 32'(STANDSTILL_CYCLES)) ? idle_q + 32'h1 : idle_q;
      currentReducedOut <= (idle_q >= 32'(STANDSTILL_CYCLES));
    end
  end

  logic trip;
  logic wrAcc;
  assign wrAcc = write & ~waitrequest; // A write lands only where its wait cycle ends.
  assign trip  = wrAcc & (address == ADDR_CTRL) & writedata[CTRL_TRIP];

  // Protection trips from software; a trip beats a clear in the same write.
  always_ff @(posedge clock) begin
    if (srst) begin
      faultOk_q <= 1'b1;
    end else if (trip) begin
      faultOk_q <= 1'b0;
    end else if (wrAcc && address == ADDR_CTRL && writedata[CTRL_FAULT_CLR]) begin
      faultOk_q <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      faultOut <= 1'b1;
    end else begin
      faultOut <= faultOk_q & ~trip;
    end
  end

  // ----------------------------------------
  // Interrupts and register bus
  // ----------------------------------------
  logic [IRQ_W-1:0] irqStat_q, irqEn_q, irqEvt;
  assign irqEvt = {trip & faultOk_q, accept & (phasePos == 11'h000), accept};

  // Events set, clear-register writes clear; a set in the same cycle wins.
  always_ff @(posedge clock) begin
    if (srst) begin
      irqStat_q <= '0;
    end else begin
      irqStat_q <= (irqStat_q & ~((wrAcc && address == ADDR_IRQ_CLR) ?
                   writedata[IRQ_W-1:0] : '0)) | irqEvt;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStat_q & irqEn_q);
    end
  end

  // Reads and writes both take one wait cycle; a write lands at the edge after the one ending it.
  always_ff @(posedge clock) begin
    if (srst) begin
      divSel_q <= DIV_SEL_RESET;
      irqEn_q  <= '0;
    end else if (wrAcc) begin
      if (address == ADDR_CTRL) divSel_q <= writedata[CTRL_DIV_LSB +: 4];
      if (address == ADDR_IRQ_EN) irqEn_q <= writedata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      readdata    <= 32'h0;
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= ~((read | write) & waitrequest);
      case (address)
        ADDR_CTRL:     readdata <= {28'h0, divSel_q};
        ADDR_STATUS:   readdata <= {27'h0, stepCw, windingEnable, currentReducedOut,
                                    faultOk_q, excitationHomeOut};
        ADDR_POSITION: readdata <= {21'h0, phasePos};
        ADDR_IRQ_STAT: readdata <= {29'h0, irqStat_q};
        ADDR_IRQ_EN:   readdata <= {29'h0, irqEn_q};
        default:       readdata <= 32'h0;
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_cw_step;
    @(posedge clock) disable iff (srst)
      (accept && dirSync && phasePos == 11'h000 && stepSize == 11'd128)
        |=> phasePos == 11'd128;
  endproperty
  a_cw_step: assert property (p_cw_step) else $error("Clockwise step wrong.");

  property p_ccw_step;
    @(posedge clock) disable iff (srst)
      (accept && !dirSync && phasePos == 11'h000) |=> phasePos == homeCycle - $past(stepSize);
  endproperty
  a_ccw_step: assert property (p_ccw_step) else $error("Counter step wrong.");

  property p_wind_off;
    @(posedge clock) disable iff (srst) windOffSync |=> !windingEnable;
  endproperty
  a_wind_off: assert property (p_wind_off) else $error("Current not removed.");

  property p_wind_on;
    @(posedge clock) disable iff (srst)
      (!windOffSync && faultOk_q) |=> windingEnable;
  endproperty
  a_wind_on: assert property (p_wind_on) else $error("Current not restored.");

  property p_base_sel;
    @(posedge clock) disable iff (srst)
      (accept && baseSelSync && dirSync && phasePos < homeCycle - 11'd128)
        |=> phasePos == $past(phasePos) + 11'd128;
  endproperty
  a_base_sel: assert property (p_base_sel) else $error("Base step not forced.");

  property p_home;
    @(posedge clock) disable iff (srst)
      ##1 excitationHomeOut == ($past(phasePos) == 11'h000);
  endproperty
  a_home: assert property (p_home) else $error("Home output wrong.");

  property p_fault;
    @(posedge clock) disable iff (srst) trip |=> (!faultOut && !faultOk_q) ##1 !windingEnable;
  endproperty
  a_fault: assert property (p_fault) else $error("Trip not handled.");

  property p_reduce;
    @(posedge clock) disable iff (srst) accept |=> !currentReducedOut [*2];
  endproperty
  a_reduce: assert property (p_reduce) else $error("Reduction while moving.");

  property p_wrap;
    @(posedge clock) disable iff (srst) phasePos < homeCycle;
  endproperty
  a_wrap: assert property (p_wrap) else $error("Position out of range.");

endmodule

/* File: rtl/step_dir_pkg.sv */
// Package for the step and direction input logic of a two-phase stepper driver.
// Assumes a single 100 MHz clock and a synchronous active-high reset.
package step_dir_pkg;

  // ----------------------------------------
  // Register map (Avalon-MM word addresses)
  // ----------------------------------------
  localparam logic [3:0] ADDR_CTRL     = 4'h0;
  localparam logic [3:0] ADDR_STATUS   = 4'h1;
  localparam logic [3:0] ADDR_POSITION = 4'h2;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h3;
  localparam logic [3:0] ADDR_IRQ_EN   = 4'h4;
  localparam logic [3:0] ADDR_IRQ_CLR  = 4'h5;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  // CTRL bits.
  localparam int CTRL_DIV_LSB   = 0;  // 4-bit step resolution selector.
  localparam int CTRL_FAULT_CLR = 4;  // Write one to clear a tripped fault.
  localparam int CTRL_TRIP      = 5;  // Write one to trip the protection.
  // STATUS bits.
  localparam int ST_HOME     = 0;
  localparam int ST_FAULT_OK = 1;
  localparam int ST_CUR_RED  = 2;
  localparam int ST_WIND_ON  = 3;
  localparam int ST_DIR      = 4;
  // Interrupt bits.
  localparam int IRQ_STEP  = 0;
  localparam int IRQ_HOME  = 1;
  localparam int IRQ_FAULT = 2;
  localparam int IRQ_W     = 3;

  // ----------------------------------------
  // Reset values and timing
  // ----------------------------------------
  localparam logic [3:0] DIV_SEL_RESET  = 4'h0;
  localparam int         CLOCK_MHZ      = 100;
  localparam int         STANDSTILL_MS  = 100;
  localparam int         STANDSTILL_CYC = STANDSTILL_MS * 1000 * CLOCK_MHZ;
  localparam int         BASE_PER_HOME  = 4;

endpackage

/* File: test/step_controller_model.sv */
// Behavioural model of the motion controller that drives the step and direction pins.
// Assumes the bench raises go after a rising edge and holds it until done is seen.
module step_controller_model (
  // Clock
  input  wire logic clock,
  // Request from the bench
  input  wire logic go,
  input  wire logic cw,
  // Controller pins and completion
  output logic      stepPulseIn,
  output logic      directionIn,
  output logic      done
);
  timeunit 1ns;
  timeprecision 1ps;

  int   cnt     = 0;
  logic pulse_q = 1'b0;
  logic dir_q   = 1'b0;
  logic done_q  = 1'b0;

  // -----------------------------
  // Pulse generator
  // -----------------------------
  // The step pin idles low; direction settles well before the pulse, so it is stable at the fall.
  assign stepPulseIn = pulse_q;
  assign directionIn = dir_q;
  assign done        = done_q;

  // One request gives one full high-then-low pulse, then waits for the driver to act.
  always @(posedge clock) begin
    if (go && !done_q) begin
      if (cnt == 0) dir_q <= cw;
      if (cnt == 5) pulse_q <= 1'b1;
      if (cnt == 9) pulse_q <= 1'b0;
      if (cnt == 18) begin
        done_q <= 1'b1;
        cnt    <= 0;
      end else begin
        done_q <= 1'b0;
        cnt    <= cnt + 1;
      end
    end else begin
      done_q <= 1'b0;
    end
  end
endmodule

/* File: test/tb_step_dir_input.sv */
// Self-checking bench for the step and direction input logic.
// Assumes a short standstill count and the controller model on the pins.
`define CHK(got, exp, msg) begin nTests++; if ((got) !== (exp)) begin badCount++; \
  $display("[FAIL] %0t %s", $time, msg); end end
module tb_step_dir_input import step_dir_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clock = 1'b0, srst = 1'b1, go = 1'b0, cw = 1'b0;
  logic        windingsOffIn = 1'b0, baseStepSelIn = 1'b1;
  logic        read = 1'b0, write = 1'b0;
  logic [3:0]  address = 4'h0;
  logic [31:0] writedata = 32'h0, rd;
  logic        stepPulseIn, directionIn, done, windingEnable, stepStrobe, stepCw;
  logic        currentReducedOut, faultOut, excitationHomeOut, irq, waitrequest;
  logic [10:0] phasePos, pos = 11'h0;
  logic [31:0] readdata;
  int          badCount = 0, nTests = 0, strobes = 0;

  step_dir_input #(.STANDSTILL_CYCLES(20)) u_dut (.clock(clock), .srst(srst),
    .stepPulseIn(stepPulseIn), .directionIn(directionIn), .windingsOffIn(windingsOffIn),
    .baseStepSelIn(baseStepSelIn), .windingEnable(windingEnable), .stepStrobe(stepStrobe),
    .stepCw(stepCw), .phasePos(phasePos), .currentReducedOut(currentReducedOut),
    .faultOut(faultOut), .excitationHomeOut(excitationHomeOut), .irq(irq),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest));
  step_controller_model u_ctl (.clock(clock), .go(go), .cw(cw),
    .stepPulseIn(stepPulseIn), .directionIn(directionIn), .done(done));

  // Clock generator.
  initial forever #5 clock = ~clock;

  // Count accepted steps so a double or missing strobe shows up.
  always @(posedge clock) if (stepStrobe === 1'b1) strobes++;

  // -----------------------------
  // Bus and step tasks
  // -----------------------------
  // One Avalon cycle; the request stands until waitrequest is seen low at an edge.
  task automatic busOp(input logic [3:0] a, input logic [31:0] d, input logic rdOp);
    int n;
    n = 0;
    address <= a;
    writedata <= d;
    read <= rdOp;
    write <= !rdOp;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (waitrequest !== 1'b0) begin
      badCount++;
      $display("[FAIL] %0t bus timeout", $time);
    end
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
  endtask

  // One step request; the expected position moves by units whether or not the step is accepted.
  task automatic doStep(input logic dirCw, input int units);
    int n;
    n = 0;
    strobes = 0;
    cw <= dirCw;
    go <= 1'b1;
    do begin
      @(negedge clock);
      n++;
    end while (done !== 1'b1 && n < 60);
    if (done !== 1'b1) begin
      badCount++;
      $display("[FAIL] %0t step timeout", $time);
    end
    @(posedge clock);
    go <= 1'b0;
    pos = dirCw ? pos + 11'(units) : pos - 11'(units);
    pos = pos & 11'h1ff;
    @(posedge clock);
  endtask

  // -----------------------------
  // Scenarios
  // -----------------------------
  // Both directions at the base step, the wrap below home and the home flag.
  task automatic testDirection();
    doStep(1'b1, 128);
    `CHK(phasePos, pos, "cw step")
    `CHK({strobes == 1, stepCw}, 2'b11, "one cw strobe")
    `CHK(excitationHomeOut, 1'b0, "home off")
    doStep(1'b0, 128);
    `CHK({phasePos, excitationHomeOut}, {11'h0, 1'b1}, "ccw to home")
    doStep(1'b0, 128);
    `CHK({phasePos, stepCw}, {11'd384, 1'b0}, "wrap below home")
    doStep(1'b1, 128);
  endtask

  // Switch resolutions, change the select only while idle, read the position back.
  task automatic testDivide();
    baseStepSelIn <= 1'b0;
    busOp(ADDR_CTRL, 32'h1, 1'b0);
    doStep(1'b1, 64);
    `CHK(phasePos, pos, "two divisions")
    busOp(ADDR_CTRL, 32'hf, 1'b0);
    doStep(1'b1, 1);
    `CHK(phasePos, pos, "128 divisions")
    baseStepSelIn <= 1'b1;
    doStep(1'b1, 128);
    `CHK(phasePos, pos, "base step forced")
    busOp(ADDR_POSITION, 32'h0, 1'b1);
    `CHK(rd[10:0], pos, "position register")
  endtask

  // Windings off drops current and steps; release restores current.
  task automatic testWindings();
    windingsOffIn <= 1'b1;
    repeat (6) @(posedge clock);
    `CHK(windingEnable, 1'b0, "current removed")
    doStep(1'b1, 0);
    `CHK(phasePos, pos, "step ignored while off")
    `CHK(strobes, 0, "no strobe while off")
    windingsOffIn <= 1'b0;
    repeat (6) @(posedge clock);
    `CHK(windingEnable, 1'b1, "current restored")
  endtask

  // Trip with the interrupt masked, then unmask, clear the fault and the status.
  task automatic testFault();
    busOp(ADDR_CTRL, 32'h20, 1'b0);
    repeat (3) @(posedge clock);
    `CHK({faultOut, windingEnable, irq}, 3'b000, "trip masked")
    doStep(1'b1, 0);
    `CHK(phasePos, pos, "step ignored while faulted")
    busOp(ADDR_IRQ_STAT, 32'h0, 1'b1);
    `CHK(rd[IRQ_FAULT], 1'b1, "fault status")
    busOp(ADDR_IRQ_EN, 32'h4, 1'b0);
    repeat (3) @(posedge clock);
    `CHK(irq, 1'b1, "irq unmasked")
    busOp(ADDR_CTRL, 32'h10, 1'b0);
    busOp(ADDR_IRQ_CLR, 32'h4, 1'b0);
    repeat (3) @(posedge clock);
    `CHK({faultOut, windingEnable, irq}, 3'b110, "fault cleared")
  endtask

  // Standstill reduction follows idle time; an unmapped read gives zero.
  task automatic testStandstill();
    doStep(1'b1, 128);
    `CHK(currentReducedOut, 1'b0, "full current after step")
    repeat (25) @(posedge clock);
    `CHK(currentReducedOut, 1'b1, "reduced at standstill")
    busOp(4'hf, 32'h0, 1'b1);
    `CHK(rd, 32'h0, "unmapped read")
  endtask

  task automatic completeRun();
    if (badCount == 0 && nTests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Main sequence: reset, reset values, then every scenario.
  initial begin
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    repeat (2) @(posedge clock);
    `CHK({faultOut, excitationHomeOut, phasePos}, {2'b11, 11'h0}, "reset")
    `CHK({waitrequest, irq, windingEnable}, 3'b101, "reset bus and current")
    testDirection();
    testDivide();
    testWindings();
    testFault();
    testStandstill();
    completeRun();
  end

  // Watchdog sized well above the whole run.
  initial begin
    repeat (20000) @(posedge clock);
    badCount++;
    completeRun();
  end
endmodule
